// ===== inc/gpio_pkg.sv
// Purpose: constants for the 21-pin general purpose port block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: pins 0-7 first port, 8-15 second port, 16-20 third port
package gpio_pkg;
    localparam int NPIN = 21;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] OFF_FIRST_DATA = 8'h00;
    localparam logic [7:0] OFF_SECOND_DATA = 8'h04;
    localparam logic [7:0] OFF_THIRD_DATA = 8'h08;
    localparam logic [7:0] OFF_FUNC_SEL = 8'h0C;
    localparam logic [7:0] OFF_DIR_SEL = 8'h10;
    localparam logic [7:0] OFF_PULL_MODE = 8'h14;
    localparam logic [7:0] OFF_FIRST_IFG = 8'h18;
    localparam logic [7:0] OFF_SECOND_IFG = 8'h1C;
    localparam logic [7:0] OFF_THIRD_IFG = 8'h20;
    localparam logic [7:0] OFF_EDGE_CTRL = 8'h24;
    localparam logic [7:0] OFF_SECOND_IEN = 8'h28;
    localparam logic [7:0] OFF_CPU_IRQ = 8'h2C;
    localparam logic [7:0] OFF_PORT_CFG = 8'h30;
    localparam logic [7:0] OFF_BIT_OP = 8'h34;
    // edge control fields
    localparam int EC_FALL_LSB = 0;
    localparam int EC_FIRST_LO_EN = 3;
    localparam int EC_FIRST_HI_EN = 4;
    localparam int EC_THIRD_EN = 5;
    localparam int EC_PAD_LOW = 6;
    localparam int EC_W = 7;
    // cpu irq register fields
    localparam int CI_EN_LSB = 0;
    localparam int CI_FLAG_LSB = 8;
    // port config fields
    localparam int PC_PULLDN_LSB = 0;
    localparam int PC_PRIO_LSB = 4;
    // bit operation fields
    localparam int BO_BIT_LSB = 4;
    localparam int BO_PORT_LSB = 8;
    // reset values, port masks, response codes and bit operations
    localparam logic [20:0] RST_DATA = 21'h1F_FFFF;
    localparam logic [20:0] RST_ZERO = 21'h00_0000;
    localparam logic [20:0] NO_PULL_MASK = 21'h00_0300;
    localparam logic [20:0] FIRST_MASK = 21'h00_00FF;
    localparam logic [20:0] SECOND_MASK = 21'h00_FF00;
    localparam logic [20:0] THIRD_MASK = 21'h1F_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {OP_CLEAR, OP_SET, OP_TOGGLE, OP_NONE} bit_op_t;
endpackage

// ===== core/gpio_ports.sv
// Purpose: 21-pin general purpose ports with pin flags, wake and dma triggers
// Assumes: single clock aclk, synchronous active-low aresetn
// Notes: pad pull resistors are driven as enables; pad drives from pin_out/pin_oe
module gpio_ports (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [20:0] pin_in,
    output logic [20:0] pin_out,
    output logic [20:0] pin_oe,
    output logic [20:0] pin_pull_up,
    output logic [20:0] pin_pull_down,
    output logic low_supply_pad_drive,
    input wire logic [20:0] periph_a_out,
    input wire logic [20:0] periph_a_oe,
    input wire logic [20:0] periph_b_out,
    input wire logic [20:0] periph_b_oe,
    output logic [20:0] periph_in,
    input wire logic deep_sleep_mode_a,
    input wire logic deep_sleep_mode_b,
    input wire logic sleep_active,
    output logic wake_req,
    output logic [2:0] port_irq_req,
    output logic first_port_dma_trigger,
    output logic second_port_dma_trigger,
    input wire logic [1:0] dma_wr,
    input wire logic [7:0] dma_wdata,
    output logic [7:0] dma_first_rdata,
    output logic [7:0] dma_second_rdata
);

    function automatic logic [20:0] port_mask(input logic [1:0] p);
        unique case (p)
            2'd0: port_mask = gpio_pkg::FIRST_MASK;
            2'd1: port_mask = gpio_pkg::SECOND_MASK;
            default: port_mask = gpio_pkg::THIRD_MASK;
        endcase
    endfunction

    function automatic logic [20:0] spread(input logic [2:0] v);
        spread = {{5{v[2]}}, {8{v[1]}}, {8{v[0]}}};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchroniser
    logic [20:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < gpio_pkg::NPIN; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= gpio_pkg::RST_DATA;
            s2_q <= gpio_pkg::RST_DATA;
            s3_q <= gpio_pkg::RST_DATA;
            lvl_q <= gpio_pkg::RST_DATA;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi4-lite slave and register file
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d, ara_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic [20:0] data_q, data_d, sel_q, sel_d, dir_q, dir_d, inp_q, inp_d;
    logic [20:0] ifg_q, ifg_d, ev;
    logic [7:0] cpu_irq_enable_two_q, cpu_irq_enable_two_d;
    logic [6:0] ec_q, ec_d;
    logic [2:0] cen_q, cen_d, cflg_q, cflg_d, pd_q, pd_d, pri_q, pri_d;
    logic do_wr, do_rd, hit;
    logic [31:0] wv;
    logic [20:0] bit_sel;
    logic [1:0] op_port;

    assign do_wr = aw_q && w_q && !bv_q;
    assign do_rd = s_axi_arvalid && !rv_q;
    assign wv = wd_q;
    assign op_port = wv[gpio_pkg::BO_PORT_LSB +: 2];
    assign ara_d = s_axi_araddr;

    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        br_d = br_q;
        if (s_axi_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        if (do_wr) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = gpio_pkg::RESP_OKAY;
            if (awa_q > gpio_pkg::OFF_BIT_OP || awa_q[1:0] != 2'b00) begin
                br_d = gpio_pkg::RESP_SLVERR;
            end
        end
    end

    always_comb begin
        data_d = data_q;
        sel_d = sel_q;
        dir_d = dir_q;
        inp_d = inp_q;
        cpu_irq_enable_two_d = cpu_irq_enable_two_q;
        ec_d = ec_q;
        cen_d = cen_q;
        pd_d = pd_q;
        pri_d = pri_q;
        bit_sel = '0;
        if (dma_wr[0]) begin
            data_d[7:0] = dma_wdata;
        end
        if (dma_wr[1]) begin
            data_d[15:8] = dma_wdata;
        end
        if (do_wr) begin
            unique case (awa_q)
                gpio_pkg::OFF_FIRST_DATA: data_d[7:0] = wv[7:0];
                gpio_pkg::OFF_SECOND_DATA: data_d[15:8] = wv[7:0];
                gpio_pkg::OFF_THIRD_DATA: data_d[20:16] = wv[4:0];
                gpio_pkg::OFF_FUNC_SEL: sel_d = wv[20:0];
                gpio_pkg::OFF_DIR_SEL: dir_d = wv[20:0];
                gpio_pkg::OFF_PULL_MODE: inp_d = wv[20:0];
                gpio_pkg::OFF_EDGE_CTRL: ec_d = wv[6:0];
                gpio_pkg::OFF_SECOND_IEN: cpu_irq_enable_two_d = wv[7:0];
                gpio_pkg::OFF_CPU_IRQ: cen_d = wv[gpio_pkg::CI_EN_LSB +: 3];
                gpio_pkg::OFF_PORT_CFG: begin
                    pd_d = wv[gpio_pkg::PC_PULLDN_LSB +: 3];
                    pri_d = wv[gpio_pkg::PC_PRIO_LSB +: 3];
                end
                // bit op modifies latch, not pins
                gpio_pkg::OFF_BIT_OP: begin
                    bit_sel = port_mask(op_port) & (21'h00_0001 << {op_port == 2'd2 ? 2'd2 : op_port, 3'd0}
                        << wv[gpio_pkg::BO_BIT_LSB +: 3]);
                    unique case (gpio_pkg::bit_op_t'(wv[1:0]))
                        gpio_pkg::OP_CLEAR: data_d = data_d & ~bit_sel;
                        gpio_pkg::OP_SET: data_d = data_d | bit_sel;
                        gpio_pkg::OP_TOGGLE: data_d = data_d ^ bit_sel;
                        gpio_pkg::OP_NONE: data_d = data_d;
                    endcase
                end
                default: data_d = data_d;
            endcase
        end
    end

    // flags set by any event; write 0 clears, set wins
    always_comb begin
        ifg_d = ifg_q;
        cflg_d = cflg_q;
        if (do_wr) begin
            unique case (awa_q)
                gpio_pkg::OFF_FIRST_IFG: ifg_d[7:0] = ifg_q[7:0] & wv[7:0];
                gpio_pkg::OFF_SECOND_IFG: ifg_d[15:8] = ifg_q[15:8] & wv[7:0];
                gpio_pkg::OFF_THIRD_IFG: ifg_d[20:16] = ifg_q[20:16] & wv[4:0];
                gpio_pkg::OFF_CPU_IRQ: cflg_d = cflg_q & wv[gpio_pkg::CI_FLAG_LSB +: 3];
                default: ifg_d = ifg_d;
            endcase
        end
        ifg_d = ifg_d | ev;
        // port-level flag raised from enabled pin events
        cflg_d = cflg_d | ({|(ev[20:16] & {5{ec_q[gpio_pkg::EC_THIRD_EN]}}),
            |(ev[15:8] & cpu_irq_enable_two_q),
            |(ev[7:0] & {{4{ec_q[gpio_pkg::EC_FIRST_HI_EN]}}, {4{ec_q[gpio_pkg::EC_FIRST_LO_EN]}}})});
    end

    always_comb begin
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
        if (do_rd) begin
            rv_d = 1'b1;
            rr_d = gpio_pkg::RESP_OKAY;
            rd_d = '0;
            unique case (ara_d)
                gpio_pkg::OFF_FIRST_DATA: rd_d[7:0] = lvl_q[7:0];
                gpio_pkg::OFF_SECOND_DATA: rd_d[7:0] = lvl_q[15:8];
                gpio_pkg::OFF_THIRD_DATA: rd_d[4:0] = lvl_q[20:16];
                gpio_pkg::OFF_FUNC_SEL: rd_d[20:0] = sel_q;
                gpio_pkg::OFF_DIR_SEL: rd_d[20:0] = dir_q;
                gpio_pkg::OFF_PULL_MODE: rd_d[20:0] = inp_q;
                gpio_pkg::OFF_FIRST_IFG: rd_d[7:0] = ifg_q[7:0];
                gpio_pkg::OFF_SECOND_IFG: rd_d[7:0] = ifg_q[15:8];
                gpio_pkg::OFF_THIRD_IFG: rd_d[4:0] = ifg_q[20:16];
                gpio_pkg::OFF_EDGE_CTRL: rd_d[6:0] = ec_q;
                gpio_pkg::OFF_SECOND_IEN: rd_d[7:0] = cpu_irq_enable_two_q;
                gpio_pkg::OFF_CPU_IRQ: begin
                    rd_d[gpio_pkg::CI_EN_LSB +: 3] = cen_q;
                    rd_d[gpio_pkg::CI_FLAG_LSB +: 3] = cflg_q;
                end
                gpio_pkg::OFF_PORT_CFG: begin
                    rd_d[gpio_pkg::PC_PULLDN_LSB +: 3] = pd_q;
                    rd_d[gpio_pkg::PC_PRIO_LSB +: 3] = pri_q;
                end
                // latch contents, as a bit op sees them
                gpio_pkg::OFF_BIT_OP: rd_d[20:0] = data_q;
                default: rr_d = gpio_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            rd_q <= 32'h0000_0000;
            br_q <= gpio_pkg::RESP_OKAY;
            rr_q <= gpio_pkg::RESP_OKAY;
            // GPIO inputs after reset; pull-up default
            data_q <= gpio_pkg::RST_DATA;
            sel_q <= gpio_pkg::RST_ZERO;
            dir_q <= gpio_pkg::RST_ZERO;
            inp_q <= gpio_pkg::RST_ZERO;
            ifg_q <= gpio_pkg::RST_ZERO;
            cpu_irq_enable_two_q <= 8'h00;
            ec_q <= 7'h00;
            cen_q <= 3'h0;
            cflg_q <= 3'h0;
            pd_q <= 3'h0;
            pri_q <= 3'h0;
        end else begin
            aw_q <= aw_d;
            w_q <= w_d;
            bv_q <= bv_d;
            rv_q <= rv_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            br_q <= br_d;
            rr_q <= rr_d;
            data_q <= data_d;
            sel_q <= sel_d;
            dir_q <= dir_d;
            inp_q <= inp_d;
            ifg_q <= ifg_d;
            cpu_irq_enable_two_q <= cpu_irq_enable_two_d;
            ec_q <= ec_d;
            cen_q <= cen_d;
            cflg_q <= cflg_d;
            pd_q <= pd_d;
            pri_q <= pri_d;
        end
    end

    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;

    ////////////////////////////////////////////////////////////////////
    // edges, flags, dma triggers, wake
    logic [20:0] gpin, rise, fall;
    logic dma0_q, dma1_q, wake_q, pad_q;
    logic [2:0] irq_q;
    logic [7:0] dr0_q, dr1_q;

    // GPIO input pins only, edge per port
    assign gpin = ~sel_q & ~dir_q;
    assign rise = lvl_d & ~lvl_q;
    assign fall = ~lvl_d & lvl_q;
    assign ev = gpin & ((rise & ~spread(ec_q[2:0])) | (fall & spread(ec_q[2:0])));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma0_q <= 1'b0;
            dma1_q <= 1'b0;
            wake_q <= 1'b0;
            irq_q <= 3'h0;
            pad_q <= 1'b0;
            dr0_q <= 8'hFF;
            dr1_q <= 8'hFF;
        end else begin
            dma0_q <= |(gpin[7:0] & (lvl_d[7:0] ^ lvl_q[7:0]));
            dma1_q <= |(gpin[15:8] & (lvl_d[15:8] ^ lvl_q[15:8]));
            wake_q <= sleep_active && (|ev);
            irq_q <= cflg_q & cen_q;
            pad_q <= ec_q[gpio_pkg::EC_PAD_LOW];
            // dma read view of pin levels
            dr0_q <= lvl_q[7:0];
            dr1_q <= lvl_q[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pad drive, peripheral muxing, sleep retention
    logic [20:0] mout, moe, b_wins, pu_d, pdn_d;
    logic [20:0] out_q, oe_q, pu_q, pdn_q, pin_q;
    logic frozen;

    assign b_wins = periph_b_oe & (~periph_a_oe | spread(pri_q));
    assign mout = sel_q & ((b_wins & periph_b_out) | (~b_wins & periph_a_out)) | (~sel_q & data_q);
    assign moe = (sel_q & (periph_a_oe | periph_b_oe)) | (~sel_q & dir_q);
    // tri-state when mode bit set; high-drive pins never pulled
    assign pu_d = ~moe & ~inp_q & ~spread(pd_q) & ~gpio_pkg::NO_PULL_MASK;
    assign pdn_d = ~moe & ~inp_q & spread(pd_q) & ~gpio_pkg::NO_PULL_MASK;
    assign frozen = deep_sleep_mode_a || deep_sleep_mode_b;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_q <= gpio_pkg::RST_DATA;
            oe_q <= gpio_pkg::RST_ZERO;
            pu_q <= ~gpio_pkg::NO_PULL_MASK;
            pdn_q <= gpio_pkg::RST_ZERO;
            pin_q <= gpio_pkg::RST_DATA;
        end else begin
            // hold mode and output in deep sleep
            if (!frozen) begin
                out_q <= mout;
                oe_q <= moe;
                pu_q <= pu_d;
                pdn_q <= pdn_d;
            end
            pin_q <= lvl_q;
        end
    end

    // port widths fixed by the masks above
    assign pin_out = out_q;
    assign pin_oe = oe_q;
    assign pin_pull_up = pu_q;
    assign pin_pull_down = pdn_q;
    assign periph_in = pin_q;
    assign low_supply_pad_drive = pad_q;
    assign wake_req = wake_q;
    assign port_irq_req = irq_q;
    assign first_port_dma_trigger = dma0_q;
    assign second_port_dma_trigger = dma1_q;
    assign dma_first_rdata = dr0_q;
    assign dma_second_rdata = dr1_q;

endmodule

// ===== tb/gpio_ports_checker.sv
// Purpose: port-level assertions for gpio_ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every gpio_ports instance
module gpio_ports_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [20:0] pin_out,
    input wire logic [20:0] pin_oe,
    input wire logic [20:0] pin_pull_up,
    input wire logic [20:0] pin_pull_down,
    input wire logic deep_sleep_mode_a,
    input wire logic deep_sleep_mode_b,
    input wire logic sleep_active,
    input wire logic wake_req,
    input wire logic first_port_dma_trigger
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    reset_pins_a: assert property ($rose(aresetn) |-> pin_oe == 21'h00_0000 && pin_pull_down == 21'h00_0000)
        else $error("pins not inputs after reset");
    no_pull_a: assert property (pin_pull_up[9:8] == 2'h0 && pin_pull_down[9:8] == 2'h0)
        else $error("high drive pin pulled");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read valid after handshake");
    sleep_freeze_a: assert property ((deep_sleep_mode_a || deep_sleep_mode_b) [*3]
        |-> $stable(pin_oe) && $stable(pin_out) && $stable(pin_pull_up))
        else $error("pins changed in deep sleep");
    wake_gate_a: assert property (wake_req |-> $past(sleep_active))
        else $error("wake outside sleep");
    dma_gate_a: assert property ((pin_oe[7:0] == 8'hFF) [*8] |-> !first_port_dma_trigger)
        else $error("dma trigger from output pins");
    cover property (wake_req);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (deep_sleep_mode_b && pin_oe[7:0] == 8'h00);
endmodule

bind gpio_ports gpio_ports_checker checker_u (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .deep_sleep_mode_a,
    .deep_sleep_mode_b, .sleep_active, .wake_req, .first_port_dma_trigger);

// ===== tb/pin_partner.sv
// Purpose: external pad model producing pin_in
// Assumes: ext_drv high means the far side drives ext_val
// Notes: undriven unpulled pins show the inverse of ext_val
module pin_partner (
    input wire logic [20:0] pin_out,
    input wire logic [20:0] pin_oe,
    input wire logic [20:0] pin_pull_up,
    input wire logic [20:0] pin_pull_down,
    input wire logic [20:0] ext_val,
    input wire logic [20:0] ext_drv,
    output logic [20:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
        | (~pin_oe & ~ext_drv & (pin_pull_up | (~pin_pull_down & ~ext_val)));
endmodule

// ===== tb/tb_gpio_ports.sv
// Purpose: directed bench for gpio_ports over AXI4-Lite
// Assumes: pin_partner models the far side of every pad
// Notes: expected values follow the register map in gpio_pkg
module tb_gpio_ports;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [20:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, periph_in;
    logic [20:0] ext_val = 21'h00_0000;
    logic [20:0] ext_drv = 21'h00_0000;
    logic [20:0] periph_a_out = 21'h00_0000;
    logic [20:0] periph_a_oe = 21'h00_0000;
    logic [20:0] periph_b_out = 21'h00_0000;
    logic [20:0] periph_b_oe = 21'h00_0000;
    logic deep_sleep_mode_a = 1'b0;
    logic deep_sleep_mode_b = 1'b0;
    logic sleep_active = 1'b0;
    logic low_supply_pad_drive, wake_req, first_port_dma_trigger, second_port_dma_trigger;
    logic [2:0] port_irq_req;
    logic [1:0] dma_wr = 2'h0;
    logic [7:0] dma_wdata = 8'h00;
    logic [7:0] dma_first_rdata, dma_second_rdata;
    logic [7:0] op_exp [4] = '{8'h85, 8'hA5, 8'h85, 8'h85};
    int err_count = 0;
    int checked = 0;
    int wake_n = 0;
    int fdma_n = 0;
    int sdma_n = 0;
    int snap;
    int wsnap;
    initial begin
        forever #4 aclk = ~aclk;
    end
    gpio_ports dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down,
        .low_supply_pad_drive, .periph_a_out, .periph_a_oe, .periph_b_out, .periph_b_oe, .periph_in,
        .deep_sleep_mode_a, .deep_sleep_mode_b, .sleep_active, .wake_req, .port_irq_req,
        .first_port_dma_trigger, .second_port_dma_trigger, .dma_wr, .dma_wdata, .dma_first_rdata,
        .dma_second_rdata);
    pin_partner model_u (.pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .ext_val, .ext_drv, .pin_in);
    always @(posedge aclk) begin
        wake_n += int'(wake_req === 1'b1);
        fdma_n += int'(first_port_dma_trigger === 1'b1);
        sdma_n += int'(second_port_dma_trigger === 1'b1);
    end
    ////////////////////////////////////////////////////////////////
    task automatic results();
        $display("counts: %0d checked, %0d mismatches", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic hang();
        err_count++;
        $display("mismatch at %0t: bus wait ran out", $time);
        results();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n <= 40; n++) begin
            if (n == 40) hang();
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                chk(32'(s_axi_bresp), 32'(er), "write response");
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n <= 40; n++) begin
            if (n == 40) hang();
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                chk(s_axi_rdata, ed, "read data");
                chk(32'(s_axi_rresp), 32'(er), "read response");
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        tick(5);
        aresetn <= 1'b1;
        chk(32'(pin_oe), 32'h0000_0000, "oe after reset");
        chk(32'(pin_pull_up), 32'h001F_FCFF, "pulls after reset");
        axi_rd(gpio_pkg::OFF_DIR_SEL, 32'h0000_0000, gpio_pkg::RESP_OKAY);
        axi_rd(gpio_pkg::OFF_FUNC_SEL, 32'h0000_0000, gpio_pkg::RESP_OKAY);
        axi_rd(gpio_pkg::OFF_SECOND_DATA, 32'h0000_00FF, gpio_pkg::RESP_OKAY);
        axi_rd(gpio_pkg::OFF_THIRD_DATA, 32'h0000_001F, gpio_pkg::RESP_OKAY);
        axi_rd(8'h38, 32'h0000_0000, gpio_pkg::RESP_SLVERR);
        axi_wr(8'h38, 32'h0000_FFFF, gpio_pkg::RESP_SLVERR);
        $display("test reset done");
        ext_drv <= 21'h1F_FFFF;
        axi_wr(gpio_pkg::OFF_DIR_SEL, 32'h0000_00F0, gpio_pkg::RESP_OKAY);
        axi_wr(gpio_pkg::OFF_FIRST_DATA, 32'h0000_00A5, gpio_pkg::RESP_OKAY);
        tick(8);
        chk(32'(pin_oe), 32'h0000_00F0, "direction");
        axi_rd(gpio_pkg::OFF_FIRST_DATA, 32'h0000_00A0, gpio_pkg::RESP_OKAY);
        $display("test direction done");
        snap = fdma_n;
        for (int i = 0; i < 4; i++) begin
            axi_wr(gpio_pkg::OFF_BIT_OP, 32'h0000_0050 | 32'(i), gpio_pkg::RESP_OKAY);
            tick(3);
            chk(32'(pin_out[7:0]), 32'(op_exp[i]), "bit operation");
        end
        chk(32'(fdma_n - snap), 32'h0000_0000, "output pins trigger dma");
        $display("test bit ops done");
        axi_wr(gpio_pkg::OFF_PULL_MODE, 32'h0000_0001, gpio_pkg::RESP_OKAY);
        axi_wr(gpio_pkg::OFF_PORT_CFG, 32'h0000_0002, gpio_pkg::RESP_OKAY);
        tick(3);
        chk(32'({pin_pull_up[15:8], pin_pull_down[15:8]}), 32'h0000_00FC, "second port pulls");
        chk(32'({pin_pull_up[1:0], pin_pull_down[1:0]}), 32'h0000_0008, "tri-state bit");
        axi_wr(gpio_pkg::OFF_DIR_SEL, 32'h0000_00FF, gpio_pkg::RESP_OKAY);
        dma_wr <= 2'h3;
        dma_wdata <= 8'h3C;
        tick(1);
        dma_wr <= 2'h0;
        tick(8);
        chk(32'(pin_out[15:0]), 32'h0000_3C3C, "dma latch write");
        chk(32'({dma_second_rdata, dma_first_rdata}), 32'h0000_003C, "dma pin read");
        chk(32'(periph_in[15:0]), 32'h0000_003C, "periph view");
        $display("test pulls and dma done");
        periph_a_oe <= 21'h01_0000;
        periph_b_oe <= 21'h01_0000;
        periph_b_out <= 21'h01_0000;
        axi_wr(gpio_pkg::OFF_FUNC_SEL, 32'h0001_0000, gpio_pkg::RESP_OKAY);
        tick(3);
        chk(32'({pin_oe[16], pin_out[16]}), 32'h0000_0002, "peripheral a drives");
        axi_wr(gpio_pkg::OFF_PORT_CFG, 32'h0000_0042, gpio_pkg::RESP_OKAY);
        tick(3);
        chk(32'({pin_oe[16], pin_out[16]}), 32'h0000_0003, "peripheral b wins");
        $display("test peripheral done");
        snap = sdma_n;
        ext_val <= 21'h00_0400;
        tick(10);
        axi_rd(gpio_pkg::OFF_SECOND_IFG, 32'h0000_0004, gpio_pkg::RESP_OKAY);
        chk(32'(port_irq_req), 32'h0000_0000, "irq without enables");
        axi_wr(gpio_pkg::OFF_SECOND_IFG, 32'h0000_0000, gpio_pkg::RESP_OKAY);
        axi_rd(gpio_pkg::OFF_SECOND_IFG, 32'h0000_0000, gpio_pkg::RESP_OKAY);
        axi_wr(gpio_pkg::OFF_SECOND_IEN, 32'h0000_0004, gpio_pkg::RESP_OKAY);
        axi_wr(gpio_pkg::OFF_CPU_IRQ, 32'h0000_0002, gpio_pkg::RESP_OKAY);
        axi_wr(gpio_pkg::OFF_EDGE_CTRL, 32'h0000_0042, gpio_pkg::RESP_OKAY);
        tick(3);
        chk(32'(low_supply_pad_drive), 32'h0000_0001, "pad supply bit");
        sleep_active <= 1'b1;
        wsnap = wake_n;
        ext_val <= 21'h00_0000;
        tick(10);
        chk(32'(port_irq_req), 32'h0000_0002, "second port irq");
        chk(32'(wake_n - wsnap), 32'h0000_0001, "wake pulse");
        chk(32'(sdma_n - snap), 32'h0000_0002, "dma per transition");
        axi_rd(gpio_pkg::OFF_CPU_IRQ, 32'h0000_0202, gpio_pkg::RESP_OKAY);
        axi_wr(gpio_pkg::OFF_SECOND_IFG, 32'h0000_0000, gpio_pkg::RESP_OKAY);
        axi_wr(gpio_pkg::OFF_CPU_IRQ, 32'h0000_0002, gpio_pkg::RESP_OKAY);
        tick(3);
        chk(32'(port_irq_req), 32'h0000_0000, "irq cleared");
        sleep_active <= 1'b0;
        $display("test interrupts done");
        for (int m = 0; m < 2; m++) begin
            {deep_sleep_mode_b, deep_sleep_mode_a} <= 2'(m + 1);
            tick(3);
            axi_wr(gpio_pkg::OFF_DIR_SEL, 32'(m * 255), gpio_pkg::RESP_OKAY);
            tick(3);
            chk(32'(pin_oe[7:0]), 32'((1 - m) * 255), "frozen in deep sleep");
            {deep_sleep_mode_b, deep_sleep_mode_a} <= 2'h0;
            tick(3);
            chk(32'(pin_oe[7:0]), 32'(m * 255), "released from deep sleep");
        end
        $display("test deep sleep done");
        results();
    end
endmodule
